// file: call_setup_clear_packet_codec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module call_setup_clear_packet_codec_tb;
  import cscpc_pkg::*;
  logic clk, resetn, rx_valid, rx_last, tx_valid, tx_last, pkt_done;
  logic fast_select_req, fast_select_unrestricted, agency_sel_used;
  logic remote_event, unknown_to_congestion, fmt_err, cause_err;
  logic mod128, dbit;
  logic [7:0] rx_data, tx_data, data_octets, cause_val, diag_val, c, d;
  logic [3:0] called_len, calling_len;
  logic [5:0] util_len;
  logic [6:0] fac_len;
  cscpc_kind_t pkt_kind;
  logic [7:0] pk [$], ex [$], txq [$];
  logic [7:0] cz [16] = '{8'h00, 8'h01, 8'h09, 8'h11, 8'h19, 8'h21, 8'h29,
    8'h39, 8'h03, 8'h0b, 8'h05, 8'h0d, 8'h15, 8'h85, 8'h07, 8'h7f};
  logic [7:0] dz [8] = '{8'h00, 8'h01, 8'h70, 8'h7f, 8'h80, 8'hc8, 8'h6f,
    8'hff};
  int n_errors = 0;
  int checks = 0;
  always #10 clk = ~clk;
  cscpc_peer u_peer (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last));
  cscpc_codec u_dut (.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .fast_select_req(fast_select_req),
    .fast_select_unrestricted(fast_select_unrestricted),
    .agency_sel_used(agency_sel_used), .remote_event(remote_event),
    .unknown_to_congestion(unknown_to_congestion), .addr_plan_e164(1'b0),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .pkt_done(pkt_done), .pkt_kind(pkt_kind), .fmt_err(fmt_err),
    .cause_err(cause_err), .mod128(mod128), .dbit(dbit),
    .called_len(called_len), .calling_len(calling_len),
    .util_len(util_len), .fac_len(fac_len), .data_octets(data_octets),
    .cause_val(cause_val), .diag_val(diag_val));
  // relayed octets collected for comparison
  always @(posedge clk) begin
    if (tx_valid === 1'b1) txq.push_back(tx_data);
  end
  // ========================================================
  // helpers
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic lv(input logic fs, un, ag, re, uc);
    @(posedge clk);
    fast_select_req <= fs;
    fast_select_unrestricted <= un;
    agency_sel_used <= ag;
    remote_event <= re;
    unknown_to_congestion <= uc;
  endtask : lv
  task automatic hdr();
    pk = {8'h50, 8'h05, 8'h0b, 8'h23, 8'h12, 8'h34, 8'h50};
  endtask : hdr
  task automatic body(input logic [7:0] ul, input int nu,
    input logic [7:0] fl, input int nf, input int nd);
    pk.push_back(ul);
    repeat (nu) pk.push_back(8'ha5);
    pk.push_back(fl);
    repeat (nf) pk.push_back(8'h5a);
    repeat (nd) pk.push_back(8'(pk.size()));
    ex = pk;
  endtask : body
  task automatic go(input logic e, input cscpc_kind_t k);
    txq.delete();
    u_peer.send(pk);
    #1;
    for (int i = 0; i < 20 && pkt_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(pkt_done, 1'b1);
    chk(fmt_err, e);
    chk(pkt_kind, k);
    @(posedge clk);
    #1;
    chk(8'(txq.size()), 8'(ex.size()));
    foreach (ex[j]) if (j < txq.size()) chk(txq[j], ex[j]);
  endtask : go
  function automatic logic known(input logic [7:0] v);
    known = v[7] || v == 8'h00;
    for (int j = 1; j < 13; j++) if (cz[j] == v) known = 1'b1;
  endfunction : known
  // ========================================================
  // tests
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {fast_select_req, fast_select_unrestricted, agency_sel_used} = 3'h0;
    {remote_event, unknown_to_congestion} = 2'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    lv(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    hdr();
    body(8'h02, 2, 8'h01, 1, 16);
    go(1'b0, CSCPC_PK_CALL_REQ);
    chk(called_len, 8'h03);
    chk(calling_len, 8'h02);
    chk(util_len, 8'h02);
    chk(fac_len, 8'h01);
    chk(data_octets, 8'h10);
    chk(dbit, 1'b1);
    chk(mod128, 1'b0);
    hdr();
    pk[0] = 8'h20;
    body(8'h02, 2, 8'h01, 1, 17);
    go(1'b1, CSCPC_PK_CALL_REQ);
    lv(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    go(1'b0, CSCPC_PK_CALL_REQ);
    chk(mod128, 1'b1);
    hdr();
    body(8'h00, 0, 8'h00, 0, 0);
    pk[4] = 8'h1a;
    ex = pk;
    go(1'b1, CSCPC_PK_CALL_REQ);
    pk[4] = 8'h12;
    pk[6] = 8'h51;
    ex = pk;
    go(1'b1, CSCPC_PK_CALL_REQ);
    pk[6] = 8'h50;
    pk[0] = 8'h90;
    ex = pk;
    go(1'b1, CSCPC_PK_CALL_REQ);
    hdr();
    body(8'h42, 2, 8'h01, 1, 0);
    go(1'b1, CSCPC_PK_CALL_REQ);
    hdr();
    body(8'h3f, 63, 8'h81, 1, 0);
    go(1'b1, CSCPC_PK_CALL_REQ);
    for (int n = 109; n < 111; n++) begin
      hdr();
      body(8'h3f, 63, 8'(n), n, 0);
      go(n > 109, CSCPC_PK_CALL_REQ);
    end
    pk = {8'h10, 8'h05, 8'h0f, 8'h00};
    body(8'h00, 0, 8'h00, 0, 4);
    go(1'b1, CSCPC_PK_CALL_CONN);
    lv(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    go(1'b0, CSCPC_PK_CALL_CONN);
    for (int p = 0; p < 32; p++) begin
      c = cz[p % 16];
      d = dz[p / 4];
      lv(1'b0, 1'b0, p % 16 != 12, p[4], p[0]);
      pk = {p[1] ? 8'h20 : 8'h10, 8'h05, 8'h13, c, d};
      ex = pk;
      ex[3] = (known(c) || !p[0]) ? c : 8'h05;
      if (ex[3] == 8'h05 && p[4] && d != 8'h00 && (d < 8'h70 || d > 8'h7f))
        ex[4] = (d <= 8'h6f) ? 8'h72 : 8'h71;
      go(1'b0, CSCPC_PK_CLEAR_REQ);
      chk(cause_val, ex[3]);
      chk(diag_val, ex[4]);
      chk(cause_err, !known(c) || (c == 8'h15 && p % 16 == 12));
    end
    pk = {8'h50, 8'h05, 8'h13, 8'h01, 8'h00};
    ex = pk;
    go(1'b1, CSCPC_PK_CLEAR_REQ);
    pk[0] = 8'h10;
    void'(pk.pop_back());
    ex = pk;
    go(1'b1, CSCPC_PK_CLEAR_REQ);
    tally_and_finish();
  end
  // watchdog against a hang
  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end
endmodule : call_setup_clear_packet_codec_tb
`default_nettype wire

// file: cscpc_cause_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "cscpc_cfg.svh"

module cscpc_cause_unit (
  input wire logic [7:0] cause_in,
  input wire logic [7:0] diag_in,
  input wire logic remote_event,
  input wire logic agency_sel_used,
  input wire logic unknown_to_congestion,
  output logic [7:0] cause_out,
  output logic [7:0] diag_out,
  output logic cause_known,
  output logic agency_refused
);

  logic net_known;

  // ========================================================
  // recognise the defined cause codes
  always_comb begin
    case (cause_in)
      `CSCPC_CAUSE_BUSY, `CSCPC_CAUSE_OUT_OF_ORDER,
      `CSCPC_CAUSE_REMOTE_PROC, `CSCPC_CAUSE_REV_CHG,
      `CSCPC_CAUSE_INCOMPAT, `CSCPC_CAUSE_FAST_SEL,
      `CSCPC_CAUSE_SHIP_ABSENT, `CSCPC_CAUSE_INV_FAC,
      `CSCPC_CAUSE_BARRED, `CSCPC_CAUSE_CONGESTION,
      `CSCPC_CAUSE_NOT_OBTAIN, `CSCPC_CAUSE_AGENCY_OOO: begin
        net_known = 1'b1;
      end
      default: begin
        net_known = 1'b0;
      end
    endcase
  end

  // remote-terminal causes and all-zero are always valid
  assign cause_known = net_known || cause_in[7] ||
    (cause_in == `CSCPC_CAUSE_DTE_ZERO);

  // agency fault only legal when agency selection was used
  assign agency_refused = (cause_in == `CSCPC_CAUSE_AGENCY_OOO) &&
    !agency_sel_used;

  // unknown causes pass or become congestion
  assign cause_out = (!cause_known && unknown_to_congestion) ?
    `CSCPC_CAUSE_CONGESTION : cause_in;

  // diagnostic pass or remap under remote congestion
  always_comb begin
    diag_out = diag_in;
    if ((cause_out == `CSCPC_CAUSE_CONGESTION) && remote_event) begin
      if (diag_in == 8'h00) begin
        diag_out = diag_in;
      end else if (diag_in <= `CSCPC_DIAG_LOW_LAST) begin
        diag_out = `CSCPC_DIAG_LOW_MAP;
      end else if (diag_in <= `CSCPC_DIAG_MID_LAST) begin
        diag_out = diag_in;
      end else begin
        diag_out = `CSCPC_DIAG_HIGH_MAP;
      end
    end
  end

endmodule : cscpc_cause_unit
`default_nettype wire

// file: cscpc_cfg.svh
`ifndef CSCPC_CFG_SVH
`define CSCPC_CFG_SVH

// ==========================================================
// octet positions
`define CSCPC_OCT_TYPE 8'd3
`define CSCPC_OCT_ALEN 8'd4
`define CSCPC_OCT_CAUSE 8'd4
`define CSCPC_OCT_DIAG 8'd5

// ==========================================================
// packet type codes (octet 3)
`define CSCPC_TYPE_CALL_REQ 8'h0b
`define CSCPC_TYPE_CALL_CONN 8'h0f
`define CSCPC_TYPE_CLEAR_REQ 8'h13

// ==========================================================
// format identifier (octet 1 upper nibble)
`define CSCPC_GFI_MOD8 2'h1
`define CSCPC_GFI_MOD128 2'h2

// ==========================================================
// clearing cause codes
`define CSCPC_CAUSE_DTE_ZERO 8'h00
`define CSCPC_CAUSE_BUSY 8'h01
`define CSCPC_CAUSE_OUT_OF_ORDER 8'h09
`define CSCPC_CAUSE_REMOTE_PROC 8'h11
`define CSCPC_CAUSE_REV_CHG 8'h19
`define CSCPC_CAUSE_INCOMPAT 8'h21
`define CSCPC_CAUSE_FAST_SEL 8'h29
`define CSCPC_CAUSE_SHIP_ABSENT 8'h39
`define CSCPC_CAUSE_INV_FAC 8'h03
`define CSCPC_CAUSE_BARRED 8'h0b
`define CSCPC_CAUSE_CONGESTION 8'h05
`define CSCPC_CAUSE_NOT_OBTAIN 8'h0d
`define CSCPC_CAUSE_AGENCY_OOO 8'h15

// ==========================================================
// diagnostic remapping under congestion
`define CSCPC_DIAG_LOW_LAST 8'd111
`define CSCPC_DIAG_MID_LAST 8'd127
`define CSCPC_DIAG_LOW_MAP 8'd114
`define CSCPC_DIAG_HIGH_MAP 8'd113

// ==========================================================
// field length limits
`define CSCPC_UTIL_MAX 8'd63
`define CSCPC_FAC_MAX 8'd109
`define CSCPC_UD_BITS_STD 128
`define CSCPC_UD_BITS_FAST 1024
`define CSCPC_X121_MAX_DIGITS 5'd15
`define CSCPC_E164_MAX_DIGITS 5'd15

`endif

// file: cscpc_codec.sv
`timescale 1ns/1ps
`default_nettype none
`include "cscpc_cfg.svh"

module cscpc_codec #(
  parameter int UD_BITS_STD = `CSCPC_UD_BITS_STD,
  parameter int UD_BITS_FAST = `CSCPC_UD_BITS_FAST
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic fast_select_req,
  input wire logic fast_select_unrestricted,
  input wire logic agency_sel_used,
  input wire logic remote_event,
  input wire logic unknown_to_congestion,
  input wire logic addr_plan_e164,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic pkt_done,
  output cscpc_pkg::cscpc_kind_t pkt_kind,
  output logic fmt_err,
  output logic cause_err,
  output logic mod128,
  output logic dbit,
  output logic [3:0] called_len,
  output logic [3:0] calling_len,
  output logic [5:0] util_len,
  output logic [6:0] fac_len,
  output logic [7:0] data_octets,
  output logic [7:0] cause_val,
  output logic [7:0] diag_val
);
  import cscpc_pkg::*;

  // ========================================================
  // limits in octets
  localparam logic [7:0] UD_OCT_STD = 8'(UD_BITS_STD / 8);
  localparam logic [7:0] UD_OCT_FAST = 8'(UD_BITS_FAST / 8);

  cscpc_state_t st_reg;
  cscpc_state_t st_adv;
  cscpc_state_t st_next;
  cscpc_kind_t kind_reg;
  logic [3:0] gfi_reg;
  logic [4:0] dig_total_reg;
  logic [4:0] dig_idx_reg;
  logic [7:0] fld_left_reg;
  logic [7:0] data_cnt_reg;
  logic [7:0] cause_reg;
  logic err_reg;
  logic cerr_reg;
  logic err_now;
  logic trunc_now;
  logic [4:0] alen_sum;
  logic [4:0] max_digits;
  logic [7:0] ud_limit;
  logic [1:0] nib_bad;
  logic [7:0] cu_cause_in;
  logic [7:0] cu_cause_out;
  logic [7:0] cu_diag_out;
  logic cu_known;
  logic cu_agency_refused;
  logic beat;

  assign beat = rx_valid;
  assign alen_sum = {1'b0, rx_data[3:0]} + {1'b0, rx_data[7:4]};

  // address plan digit ceiling
  assign max_digits = addr_plan_e164 ? `CSCPC_E164_MAX_DIGITS :
    `CSCPC_X121_MAX_DIGITS;

  // user data ceiling for the packet in hand
  always_comb begin
    ud_limit = 8'h00;
    if (kind_reg == CSCPC_PK_CALL_REQ) begin
      ud_limit = fast_select_req ? UD_OCT_FAST : UD_OCT_STD;
    end else if (kind_reg == CSCPC_PK_CALL_CONN) begin
      ud_limit = fast_select_unrestricted ? UD_OCT_FAST : 8'h00;
    end
  end

  // ========================================================
  // per-nibble address digit checks
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_nib
      logic [4:0] idx;
      logic [3:0] nib;
      assign idx = dig_idx_reg + 5'(1 - gi);
      assign nib = rx_data[gi*4 +: 4];
      always_comb begin
        nib_bad[gi] = 1'b0;
        if (idx < dig_total_reg) begin
          nib_bad[gi] = (nib > 4'h9);
        end else begin
          nib_bad[gi] = (nib != 4'h0);
        end
      end
    end
  endgenerate

  // ========================================================
  // cause and diagnostic mapping
  assign cu_cause_in = (st_reg == CSCPC_ST_CAUSE) ? rx_data : cause_reg;

  cscpc_cause_unit u_cause (
    .cause_in(cu_cause_in),
    .diag_in(rx_data),
    .remote_event(remote_event),
    .agency_sel_used(agency_sel_used),
    .unknown_to_congestion(unknown_to_congestion),
    .cause_out(cu_cause_out),
    .diag_out(cu_diag_out),
    .cause_known(cu_known),
    .agency_refused(cu_agency_refused)
  );

  // ========================================================
  // field walk, one octet per beat
  always_comb begin
    st_adv = st_reg;
    case (st_reg)
      CSCPC_ST_GFI: begin
        st_adv = CSCPC_ST_LCN;
      end
      CSCPC_ST_LCN: begin
        st_adv = CSCPC_ST_TYPE;
      end
      CSCPC_ST_TYPE: begin
        case (rx_data)
          `CSCPC_TYPE_CALL_REQ, `CSCPC_TYPE_CALL_CONN: begin
            st_adv = CSCPC_ST_ALEN;
          end
          `CSCPC_TYPE_CLEAR_REQ: begin
            st_adv = CSCPC_ST_CAUSE;
          end
          default: begin
            st_adv = CSCPC_ST_PASS;
          end
        endcase
      end
      CSCPC_ST_ALEN: begin
        // empty address allowed in call connected
        st_adv = (alen_sum == 5'd0) ? CSCPC_ST_ULEN : CSCPC_ST_ADDR;
      end
      CSCPC_ST_ADDR: begin
        if (fld_left_reg == 8'd1) begin
          st_adv = CSCPC_ST_ULEN;
        end
      end
      CSCPC_ST_ULEN: begin
        st_adv = (rx_data[5:0] == 6'd0) ? CSCPC_ST_FLEN : CSCPC_ST_UTIL;
      end
      CSCPC_ST_UTIL: begin
        if (fld_left_reg == 8'd1) begin
          st_adv = CSCPC_ST_FLEN;
        end
      end
      CSCPC_ST_FLEN: begin
        st_adv = (rx_data[6:0] == 7'd0) ? CSCPC_ST_DATA : CSCPC_ST_FAC;
      end
      CSCPC_ST_FAC: begin
        if (fld_left_reg == 8'd1) begin
          st_adv = CSCPC_ST_DATA;
        end
      end
      CSCPC_ST_DATA: begin
        st_adv = CSCPC_ST_DATA;
      end
      CSCPC_ST_CAUSE: begin
        st_adv = CSCPC_ST_DIAG;
      end
      CSCPC_ST_DIAG: begin
        st_adv = CSCPC_ST_PASS;
      end
      CSCPC_ST_PASS: begin
        st_adv = CSCPC_ST_PASS;
      end
      default: begin
        st_adv = CSCPC_ST_PASS;
      end
    endcase
    st_next = rx_last ? CSCPC_ST_GFI : st_adv;
  end

  // packet ending before its mandatory fields
  assign trunc_now = rx_last && (st_adv != CSCPC_ST_DATA) &&
    (st_adv != CSCPC_ST_PASS);

  // ========================================================
  // format checks on the current octet
  always_comb begin
    err_now = 1'b0;
    case (st_reg)
      CSCPC_ST_TYPE: begin
        if ((rx_data == `CSCPC_TYPE_CALL_REQ) ||
            (rx_data == `CSCPC_TYPE_CALL_CONN)) begin
          err_now = gfi_reg[3] || ((gfi_reg[1:0] != `CSCPC_GFI_MOD8) &&
            (gfi_reg[1:0] != `CSCPC_GFI_MOD128));
        end else if (rx_data == `CSCPC_TYPE_CLEAR_REQ) begin
          err_now = (gfi_reg[3:2] != 2'b00) ||
            ((gfi_reg[1:0] != `CSCPC_GFI_MOD8) &&
            (gfi_reg[1:0] != `CSCPC_GFI_MOD128));
        end
      end
      CSCPC_ST_ALEN: begin
        err_now = (alen_sum > (max_digits << 1)) ||
          (rx_data[3:0] > max_digits[3:0] && max_digits < 5'd16);
      end
      CSCPC_ST_ADDR: begin
        err_now = |nib_bad;
      end
      CSCPC_ST_ULEN: begin
        err_now = (rx_data[7:6] != 2'b00) ||
          ({2'b00, rx_data[5:0]} > `CSCPC_UTIL_MAX);
      end
      CSCPC_ST_FLEN: begin
        err_now = rx_data[7] ||
          ({1'b0, rx_data[6:0]} > `CSCPC_FAC_MAX);
      end
      CSCPC_ST_DATA: begin
        err_now = (data_cnt_reg >= ud_limit);
      end
      default: begin
        err_now = 1'b0;
      end
    endcase
  end

  // ========================================================
  // parser state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= CSCPC_ST_GFI;
    end else if (beat) begin
      st_reg <= st_next;
    end
  end

  // ========================================================
  // header capture: identifier and type
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gfi_reg <= 4'h0;
      kind_reg <= CSCPC_PK_OTHER;
    end else if (beat) begin
      if (st_reg == CSCPC_ST_GFI) begin
        gfi_reg <= rx_data[7:4];
        kind_reg <= CSCPC_PK_OTHER;
      end else if (st_reg == CSCPC_ST_TYPE) begin
        case (rx_data)
          `CSCPC_TYPE_CALL_REQ: kind_reg <= CSCPC_PK_CALL_REQ;
          `CSCPC_TYPE_CALL_CONN: kind_reg <= CSCPC_PK_CALL_CONN;
          `CSCPC_TYPE_CLEAR_REQ: kind_reg <= CSCPC_PK_CLEAR_REQ;
          default: kind_reg <= CSCPC_PK_OTHER;
        endcase
      end
    end
  end

  // ========================================================
  // field octet counters and address digit index
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fld_left_reg <= 8'h00;
      dig_total_reg <= 5'h00;
      dig_idx_reg <= 5'h00;
    end else if (beat) begin
      case (st_reg)
        CSCPC_ST_ALEN: begin
          // called and calling share one packed run
          dig_total_reg <= alen_sum;
          dig_idx_reg <= 5'h00;
          fld_left_reg <= {4'h0, 4'((alen_sum + 5'd1) >> 1)};
        end
        CSCPC_ST_ADDR: begin
          dig_idx_reg <= dig_idx_reg + 5'd2;
          fld_left_reg <= fld_left_reg - 8'd1;
        end
        CSCPC_ST_ULEN: begin
          fld_left_reg <= {2'b00, rx_data[5:0]};
        end
        CSCPC_ST_FLEN: begin
          fld_left_reg <= {1'b0, rx_data[6:0]};
        end
        CSCPC_ST_UTIL, CSCPC_ST_FAC: begin
          fld_left_reg <= fld_left_reg - 8'd1;
        end
        default: begin
          fld_left_reg <= fld_left_reg;
        end
      endcase
    end
  end

  // ========================================================
  // user data octet count, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_cnt_reg <= 8'h00;
    end else if (beat) begin
      if (rx_last) begin
        data_cnt_reg <= 8'h00;
      end else if (st_reg == CSCPC_ST_DATA && data_cnt_reg != 8'hff) begin
        data_cnt_reg <= data_cnt_reg + 8'd1;
      end
    end
  end

  // ========================================================
  // running error flags for the packet in hand
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_reg <= 1'b0;
      cerr_reg <= 1'b0;
      cause_reg <= 8'h00;
    end else if (beat) begin
      if (rx_last) begin
        err_reg <= 1'b0;
        cerr_reg <= 1'b0;
      end else begin
        err_reg <= err_reg || err_now;
        if (st_reg == CSCPC_ST_CAUSE) begin
          cause_reg <= rx_data;
          cerr_reg <= !cu_known || cu_agency_refused;
        end
      end
    end
  end

  // ========================================================
  // relay path, one cycle behind the receive side
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else begin
      tx_valid <= beat;
      tx_last <= beat && rx_last;
      if (beat) begin
        case (st_reg)
          CSCPC_ST_CAUSE: tx_data <= cu_cause_out;
          CSCPC_ST_DIAG: tx_data <= cu_diag_out;
          default: tx_data <= rx_data;
        endcase
      end
    end
  end

  // ========================================================
  // per-packet summary, updated on the last octet
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pkt_done <= 1'b0;
      pkt_kind <= CSCPC_PK_OTHER;
      fmt_err <= 1'b0;
      cause_err <= 1'b0;
      mod128 <= 1'b0;
      dbit <= 1'b0;
    end else begin
      pkt_done <= beat && rx_last;
      if (beat && rx_last) begin
        pkt_kind <= (st_reg == CSCPC_ST_TYPE) ? CSCPC_PK_OTHER : kind_reg;
        fmt_err <= err_reg || err_now || trunc_now;
        cause_err <= cerr_reg;
        mod128 <= (gfi_reg[1:0] == `CSCPC_GFI_MOD128);
        dbit <= gfi_reg[2];
      end
    end
  end

  // ========================================================
  // captured field values
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      called_len <= 4'h0;
      calling_len <= 4'h0;
      util_len <= 6'h00;
      fac_len <= 7'h00;
      data_octets <= 8'h00;
      cause_val <= 8'h00;
      diag_val <= 8'h00;
    end else if (beat) begin
      case (st_reg)
        CSCPC_ST_GFI: begin
          called_len <= 4'h0;
          calling_len <= 4'h0;
          util_len <= 6'h00;
          fac_len <= 7'h00;
        end
        CSCPC_ST_ALEN: begin
          called_len <= rx_data[3:0];
          calling_len <= rx_data[7:4];
        end
        CSCPC_ST_ULEN: util_len <= rx_data[5:0];
        CSCPC_ST_FLEN: fac_len <= rx_data[6:0];
        CSCPC_ST_CAUSE: cause_val <= cu_cause_out;
        CSCPC_ST_DIAG: diag_val <= cu_diag_out;
        default: begin
          called_len <= called_len;
        end
      endcase
      if (rx_last) begin
        data_octets <= (st_reg == CSCPC_ST_DATA &&
          data_cnt_reg != 8'hff) ? data_cnt_reg + 8'd1 : data_cnt_reg;
      end
    end
  end

endmodule : cscpc_codec
`default_nettype wire

// file: cscpc_codec_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cscpc_codec_monitor
  import cscpc_pkg::*;
#(
  parameter int UD_BITS_STD = 128,
  parameter int UD_BITS_FAST = 1024
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic fast_select_req,
  input wire logic agency_sel_used,
  input wire logic remote_event,
  input wire logic unknown_to_congestion,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic pkt_done,
  input wire cscpc_pkg::cscpc_kind_t pkt_kind,
  input wire logic fmt_err,
  input wire logic cause_err,
  input wire logic mod128,
  input wire logic dbit,
  input wire logic [3:0] called_len,
  input wire logic [3:0] calling_len,
  input wire logic [7:0] data_octets,
  input wire logic [7:0] cause_val,
  input wire logic [7:0] diag_val
);
  logic [7:0] n_reg;
  logic [7:0] cap [1:5];
  logic [7:0] s [1:5];
  logic lb;
  logic clr;
  // ========================================================
  // octet position, saturating on long packets
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      n_reg <= 8'h01;
    end else if (rx_valid) begin
      n_reg <= rx_last ? 8'h01 : n_reg + {7'h00, n_reg != 8'hff};
    end
  end
  // first five octets, frozen at packet end
  always_ff @(posedge clk) begin
    if (rx_valid && n_reg < 8'h06) begin
      cap[n_reg[2:0]] <= rx_data;
    end
    if (rx_valid && rx_last) begin
      for (int k = 1; k < 6; k++) begin
        s[k] <= (n_reg == 8'(k)) ? rx_data : cap[k];
      end
    end
  end
  assign lb = rx_valid && rx_last;
  assign clr = pkt_done && pkt_kind == CSCPC_PK_CLEAR_REQ && !fmt_err;
  function automatic cscpc_kind_t kind_of(input logic [7:0] t);
    case (t)
      8'h0b: return CSCPC_PK_CALL_REQ;
      8'h0f: return CSCPC_PK_CALL_CONN;
      8'h13: return CSCPC_PK_CLEAR_REQ;
      default: return CSCPC_PK_OTHER;
    endcase
  endfunction : kind_of
  function automatic logic [7:0] remap(input logic [7:0] d);
    if (d == 8'h00 || (d >= 8'h70 && d <= 8'h7f)) return d;
    return (d <= 8'h6f) ? 8'h72 : 8'h71;
  endfunction : remap
  // ========================================================
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_relay_one_cycle: assert property (tx_valid == $past(rx_valid))
    else $error("relay not one cycle behind");
  a_done_after_last: assert property (lb |=> pkt_done && tx_last)
    else $error("no packet end after last octet");
  a_done_needs_last: assert property (pkt_done |-> $past(lb))
    else $error("packet end without last octet");
  a_type_kind_map: assert property (pkt_done |-> pkt_kind == kind_of(s[3]))
    else $error("packet kind wrong for type octet");
  a_gfi_flag_bits: assert property (pkt_done && !fmt_err &&
    pkt_kind inside {CSCPC_PK_CALL_REQ, CSCPC_PK_CALL_CONN} |->
    mod128 == (s[1][5:4] == 2'b10) && dbit == s[1][6])
    else $error("format flags wrong");
  a_addr_counts: assert property (pkt_done &&
    pkt_kind == CSCPC_PK_CALL_REQ |->
    called_len == s[4][3:0] && calling_len == s[4][7:4])
    else $error("address counts wrong");
  a_data_limit: assert property (pkt_done && !fmt_err &&
    pkt_kind == CSCPC_PK_CALL_REQ |-> data_octets <=
    (fast_select_req ? 8'(UD_BITS_FAST / 8) : 8'(UD_BITS_STD / 8)))
    else $error("data over limit accepted");
  a_cause_relay: assert property (clr && !unknown_to_congestion |->
    cause_val == s[4])
    else $error("cause altered");
  a_agency_flag: assert property (pkt_done && s[4] == 8'h15 &&
    pkt_kind == CSCPC_PK_CLEAR_REQ && !agency_sel_used |-> cause_err)
    else $error("agency cause not flagged");
  a_diag_relay: assert property (clr && !cause_err &&
    cause_val != 8'h05 |-> diag_val == s[5])
    else $error("diagnostic altered");
  a_diag_remap: assert property (clr && remote_event &&
    cause_val == 8'h05 |-> diag_val == remap(s[5]))
    else $error("diagnostic remap wrong");
  a_err_holds: assert property (!pkt_done |-> $stable(fmt_err))
    else $error("format flag moved between packets");
endmodule : cscpc_codec_monitor
bind cscpc_codec cscpc_codec_monitor #(
  .UD_BITS_STD(UD_BITS_STD),
  .UD_BITS_FAST(UD_BITS_FAST)
) u_mon (
  .clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_last(rx_last), .fast_select_req(fast_select_req),
  .agency_sel_used(agency_sel_used), .remote_event(remote_event),
  .unknown_to_congestion(unknown_to_congestion), .tx_valid(tx_valid),
  .tx_last(tx_last), .pkt_done(pkt_done), .pkt_kind(pkt_kind),
  .fmt_err(fmt_err), .cause_err(cause_err), .mod128(mod128), .dbit(dbit),
  .called_len(called_len), .calling_len(calling_len),
  .data_octets(data_octets), .cause_val(cause_val), .diag_val(diag_val)
);
`default_nettype wire

// file: cscpc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module cscpc_peer (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last
);
  logic busy = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
  end
  // idle data line wanders so a stale octet never looks held
  always @(posedge clk) begin
    if (!busy) rx_data <= ~rx_data;
  end
  // octet 1 first, ascending, back to back, last flagged
  task automatic send(input logic [7:0] q [$]);
    busy = 1'b1;
    foreach (q[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
      rx_last <= (i == q.size() - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    busy = 1'b0;
  endtask : send
endmodule : cscpc_peer
`default_nettype wire

// file: cscpc_pkg.sv
`default_nettype none
package cscpc_pkg;

  // ========================================================
  // parser states
  typedef enum logic [3:0] {
    CSCPC_ST_GFI = 4'b0000,
    CSCPC_ST_LCN = 4'b0001,
    CSCPC_ST_TYPE = 4'b0010,
    CSCPC_ST_ALEN = 4'b0011,
    CSCPC_ST_ADDR = 4'b0100,
    CSCPC_ST_ULEN = 4'b0101,
    CSCPC_ST_UTIL = 4'b0110,
    CSCPC_ST_FLEN = 4'b0111,
    CSCPC_ST_FAC = 4'b1000,
    CSCPC_ST_DATA = 4'b1001,
    CSCPC_ST_CAUSE = 4'b1010,
    CSCPC_ST_DIAG = 4'b1011,
    CSCPC_ST_PASS = 4'b1100
  } cscpc_state_t;

  // ========================================================
  // kind of the last packet seen
  typedef enum logic [1:0] {
    CSCPC_PK_OTHER = 2'b00,
    CSCPC_PK_CALL_REQ = 2'b01,
    CSCPC_PK_CALL_CONN = 2'b10,
    CSCPC_PK_CLEAR_REQ = 2'b11
  } cscpc_kind_t;

endpackage : cscpc_pkg
`default_nettype wire
